//--- rtl/status_readback.sv
// status, interrupt and result readback logic with a link-clock register port
`timescale 1ns/10ps
`default_nettype none

module status_readback
    import status_readback_pkg::*;
#(
    parameter bit FOUR_CHANNEL = 1'b1
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic conv_done,
    input wire logic [1:0] conv_ch,
    input wire logic [27:0] conv_data,
    input wire logic conv_last,
    input wire logic [NUM_ERR-1:0] err_event,
    input wire logic [1:0] err_ch,
    input wire logic shutdown_pin,
    input wire logic clk_link,
    input wire logic link_req,
    input wire logic link_wr,
    input wire logic [7:0] link_addr,
    input wire logic [15:0] link_wdata,
    output logic link_ack,
    output logic link_busy,
    output logic [15:0] link_rdata,
    output logic irq_n_pin,
    output logic sleep_mode,
    output deglitch_bw_t deglitch_bw
);
    localparam logic [1:0] NCH_TOP = FOUR_CHANNEL ? 2'h3 : 2'h1;

    // true for an address that holds a result upper word
    function automatic logic is_upper(input logic [7:0] a);
        is_upper = (a[7:3] == 5'h00) && !a[0];
    endfunction : is_upper

    // channel number of a result address
    function automatic logic [1:0] ch_of(input logic [7:0] a);
        ch_of = a[2:1];
    endfunction : ch_of

    // ---------------- link domain ----------------
    logic req_tgl_q; // flips once per accepted request
    logic [7:0] addr_hold_q; // held steady until the answer returns
    logic wr_hold_q;
    logic [15:0] wdata_hold_q;
    logic ack_s1_q, ack_s2_q, ack_s3_q; // answer toggle synchroniser
    logic link_busy_q;
    logic link_ack_q;
    logic [15:0] link_rdata_q;
    logic [15:0] rdata_sys_q; // answer word, stable once ack toggles
    logic ack_tgl_q; // flips once per answer, written on the system clock

    // take a request; ignored while one is still in flight
    always_ff @(posedge clk_link or negedge rstn) begin
        if (!rstn) begin
            req_tgl_q <= 1'b0;
            addr_hold_q <= 8'h00;
            wr_hold_q <= 1'b0;
            wdata_hold_q <= 16'h0000;
        end else if (link_req && !link_busy_q) begin
            req_tgl_q <= !req_tgl_q;
            addr_hold_q <= link_addr;
            wr_hold_q <= link_wr;
            wdata_hold_q <= link_wdata;
        end
    end

    // answer toggle comes back across three flops
    always_ff @(posedge clk_link or negedge rstn) begin
        if (!rstn) begin
            ack_s1_q <= 1'b0;
            ack_s2_q <= 1'b0;
            ack_s3_q <= 1'b0;
        end else begin
            ack_s1_q <= ack_tgl_q;
            ack_s2_q <= ack_s1_q;
            ack_s3_q <= ack_s2_q;
        end
    end

    // busy from request until the answer arrives
    always_ff @(posedge clk_link or negedge rstn) begin
        if (!rstn) begin
            link_busy_q <= 1'b0;
            link_ack_q <= 1'b0;
            link_rdata_q <= 16'h0000;
        end else begin
            link_ack_q <= ack_s2_q ^ ack_s3_q;
            if (ack_s2_q ^ ack_s3_q) begin
                // rdata_sys_q settled on the same edge that flipped the toggle
                link_rdata_q <= rdata_sys_q;
                link_busy_q <= 1'b0;
            end else if (link_req) begin
                link_busy_q <= 1'b1;
            end
        end
    end

    assign link_ack = link_ack_q;
    assign link_busy = link_busy_q;
    assign link_rdata = link_rdata_q;

    // ---------------- system domain ----------------
    logic req_s1_q, req_s2_q, req_s3_q; // request toggle synchroniser
    logic sd_s1_q, sd_s2_q; // shutdown pin synchroniser
    logic [15:0] mask_q; // fault_report_mask
    logic [15:0] cfg_q; // device config
    logic [15:0] seq_q; // channel_sequence_config
    logic soft_rst_q; // one-cycle software reset
    logic [NUM_ERR-1:0] err_live_q; // sticky errors since last status read
    logic [1:0] fault_ch_q; // channel of the latest error
    logic drdy_live_q; // group conversion complete
    logic [NUM_CH-1:0] unread_q; // unread_result_flag per channel
    logic [15:0] snap_q; // event_status as the host sees it
    logic [27:0] result_buf_q [NUM_CH]; // newest result per channel
    logic [15:0] lower_q [NUM_CH]; // result_lower_word per channel
    logic irq_n_q;
    deglitch_bw_t bw_q;

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            req_s1_q <= 1'b0;
            req_s2_q <= 1'b0;
            req_s3_q <= 1'b0;
            sd_s1_q <= 1'b0;
            sd_s2_q <= 1'b0;
        end else begin
            req_s1_q <= req_tgl_q;
            req_s2_q <= req_s1_q;
            req_s3_q <= req_s2_q;
            sd_s1_q <= shutdown_pin;
            sd_s2_q <= sd_s1_q;
        end
    end

    logic acc; // one access this cycle, fields from the held link words
    logic rd_status, rd_upper;
    logic [1:0] acc_ch;
    logic chan_ok;
    logic clr_all; // sleep, shutdown or software reset
    logic release_snap;
    logic conv_ok;
    logic [15:0] live_status;
    logic irq_cond;

    assign acc = req_s2_q ^ req_s3_q;
    assign acc_ch = ch_of(addr_hold_q);
    assign chan_ok = acc_ch <= NCH_TOP;
    assign rd_status = acc && !wr_hold_q && (addr_hold_q == OFS_EVENT_STATUS);
    assign rd_upper = acc && !wr_hold_q && is_upper(addr_hold_q) && chan_ok;
    assign clr_all = cfg_q[CFG_SLEEP_BIT] || sd_s2_q || soft_rst_q;
    // status or upper read lets go
    assign release_snap = rd_status || rd_upper;
    assign conv_ok = conv_done && (conv_ch <= NCH_TOP) && !clr_all;

    // writable registers; the soft reset bit self-clears
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            mask_q <= RST_FAULT_REPORT_MASK;
            cfg_q <= RST_DEVICE_CONFIG;
            seq_q <= RST_CHANNEL_SEQUENCE_CONFIG;
            soft_rst_q <= 1'b0;
        end else begin
            soft_rst_q <= 1'b0;
            if (soft_rst_q) begin
                mask_q <= RST_FAULT_REPORT_MASK;
                cfg_q <= RST_DEVICE_CONFIG;
                seq_q <= RST_CHANNEL_SEQUENCE_CONFIG;
            end else if (acc && wr_hold_q) begin
                if (addr_hold_q == OFS_FAULT_REPORT_MASK) begin
                    mask_q <= wdata_hold_q;
                end else if (addr_hold_q == OFS_DEVICE_CONFIG) begin
                    cfg_q <= wdata_hold_q;
                end else if (addr_hold_q == OFS_CHANNEL_SEQUENCE_CONFIG) begin
                    seq_q <= wdata_hold_q;
                end else if (addr_hold_q == OFS_SOFT_RESET) begin
                    soft_rst_q <= wdata_hold_q[SOFT_RESET_BIT];
                end
            end
        end
    end

    // field decode; single setting for all inputs
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            bw_q <= BW_33MHZ;
        end else begin
            case (seq_q[SEQ_DEGLITCH_LSB +: 3])
                DGL_1P0: bw_q <= BW_1P0MHZ;
                DGL_3P3: bw_q <= BW_3P3MHZ;
                DGL_10: bw_q <= BW_10MHZ;
                DGL_33: bw_q <= BW_33MHZ;
                // undefined codes fall back to the widest, never filtering signal
                default: bw_q <= BW_33MHZ;
            endcase
        end
    end

    // sticky live events; set beats a same-cycle read clear
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            err_live_q <= '0;
            fault_ch_q <= 2'h0;
            drdy_live_q <= 1'b0;
        end else if (clr_all) begin
            err_live_q <= '0;
            fault_ch_q <= 2'h0;
            drdy_live_q <= 1'b0;
        end else begin
            // new event wins; read clears errors
            err_live_q <= (rd_status ? '0 : err_live_q) | err_event;
            if (|err_event) begin
                fault_ch_q <= err_ch;
            end else if (rd_status) begin
                fault_ch_q <= 2'h0;
            end
            // last channel of the group done
            drdy_live_q <= (rd_status ? 1'b0 : drdy_live_q) || (conv_ok && conv_last);
        end
    end

    // unread flag set by a result, cleared by upper read
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            unread_q <= '0;
        end else if (clr_all) begin
            unread_q <= '0;
        end else begin
            for (int i = 0; i < NUM_CH; i++) begin
                // upper read clears; fresh result wins
                if (conv_ok && (conv_ch == i[1:0])) begin
                    unread_q[i] <= 1'b1;
                end else if (rd_upper && (acc_ch == i[1:0])) begin
                    unread_q[i] <= 1'b0;
                end
            end
        end
    end

    always_comb begin
        live_status = 16'h0000;
        live_status[ST_UNREAD_LSB +: NUM_CH] = unread_q;
        live_status[ST_DRDY_BIT] = drdy_live_q;
        live_status[ST_ERR_LSB +: NUM_ERR] = err_live_q;
        live_status[ST_FCH_LSB +: 2] = fault_ch_q;
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            snap_q <= 16'h0000;
        end else if (clr_all || release_snap) begin
            snap_q <= 16'h0000;
        end else if (snap_q == 16'h0000) begin
            // only an empty snapshot follows live state
            snap_q <= live_status;
        end
    end

    assign irq_cond = (|(snap_q[ST_ERR_LSB +: NUM_ERR] & mask_q[ST_ERR_LSB +: NUM_ERR]))
        || (snap_q[ST_DRDY_BIT] && mask_q[MASK_DRDY_BIT]);

    // disable holds pin high; drop on release or clear
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            irq_n_q <= 1'b1;
        end else begin
            irq_n_q <= !(irq_cond && !cfg_q[CFG_IRQ_DIS_BIT] && !release_snap && !clr_all);
        end
    end

    // newest result buffered, overwriting the old
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < NUM_CH; i++) begin
                result_buf_q[i] <= 28'h0000000;
            end
        end else if (clr_all) begin
            for (int i = 0; i < NUM_CH; i++) begin
                result_buf_q[i] <= 28'h0000000;
            end
        end else if (conv_ok) begin
            result_buf_q[conv_ch] <= conv_data;
        end
    end

    // lower word loaded only by an upper read
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < NUM_CH; i++) begin
                lower_q[i] <= 16'h0000;
            end
        end else if (clr_all) begin
            for (int i = 0; i < NUM_CH; i++) begin
                lower_q[i] <= 16'h0000;
            end
        end else if (rd_upper) begin
            lower_q[acc_ch] <= result_buf_q[acc_ch][15:0];
        end
    end

    // answer word and handshake back; lower read returns held copy
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rdata_sys_q <= 16'h0000;
            ack_tgl_q <= 1'b0;
        end else if (acc) begin
            ack_tgl_q <= !ack_tgl_q;
            if (wr_hold_q) begin
                rdata_sys_q <= 16'h0000;
            end else if (addr_hold_q == OFS_EVENT_STATUS) begin
                rdata_sys_q <= snap_q;
            end else if (addr_hold_q == OFS_FAULT_REPORT_MASK) begin
                rdata_sys_q <= mask_q;
            end else if (addr_hold_q == OFS_DEVICE_CONFIG) begin
                rdata_sys_q <= cfg_q;
            end else if (addr_hold_q == OFS_CHANNEL_SEQUENCE_CONFIG) begin
                rdata_sys_q <= seq_q;
            end else if (rd_upper) begin
                // upper word straight from the buffer
                rdata_sys_q <= {4'h0, result_buf_q[acc_ch][27:16]};
            end else if ((addr_hold_q[7:3] == 5'h00) && chan_ok) begin
                rdata_sys_q <= lower_q[acc_ch];
            end else begin
                // absent channels and unmapped offsets read zero
                rdata_sys_q <= 16'h0000;
            end
        end
    end

    assign irq_n_pin = irq_n_q;
    assign sleep_mode = cfg_q[CFG_SLEEP_BIT];
    assign deglitch_bw = bw_q;

    // ---------------- checks ----------------
    property p_deglitch;
        @(posedge clk_sys) disable iff (!rstn)
        (seq_q[2:0] == DGL_3P3) |=> (bw_q == BW_3P3MHZ);
    endproperty
    a_deglitch: assert property (p_deglitch) else $error("filter decode wrong");

    property p_irq_masked;
        @(posedge clk_sys) disable iff (!rstn)
        !irq_n_q |-> $past(irq_cond);
    endproperty
    a_irq_masked: assert property (p_irq_masked) else $error("unmasked irq");

    property p_irq_disable;
        @(posedge clk_sys) disable iff (!rstn)
        cfg_q[CFG_IRQ_DIS_BIT] |=> irq_n_q;
    endproperty
    a_irq_disable: assert property (p_irq_disable) else $error("irq while disabled");

    property p_freeze;
        @(posedge clk_sys) disable iff (!rstn)
        ((snap_q != 16'h0000) && !release_snap && !clr_all) |=> $stable(snap_q);
    endproperty
    a_freeze: assert property (p_freeze) else $error("snapshot changed");

    property p_release;
        @(posedge clk_sys) disable iff (!rstn)
        release_snap |=> irq_n_q && (snap_q == 16'h0000);
    endproperty
    a_release: assert property (p_release) else $error("release kept irq");

    property p_clear_all;
        @(posedge clk_sys) disable iff (!rstn)
        clr_all |=> irq_n_q && (snap_q == 16'h0000) && (lower_q[0] == 16'h0000);
    endproperty
    a_clear_all: assert property (p_clear_all) else $error("clear left state");

    property p_err_wins;
        @(posedge clk_sys) disable iff (!rstn)
        (rd_status && (|err_event) && !clr_all) |=> (err_live_q != '0);
    endproperty
    a_err_wins: assert property (p_err_wins) else $error("event lost on read");

    property p_upper_load;
        @(posedge clk_sys) disable iff (!rstn)
        (rd_upper && !clr_all && !(conv_ok && conv_ch == acc_ch))
            |=> (lower_q[$past(acc_ch)] == $past(result_buf_q[acc_ch][15:0]))
            && !unread_q[$past(acc_ch)];
    endproperty
    a_upper_load: assert property (p_upper_load) else $error("upper read failed");

    property p_lower_hold;
        @(posedge clk_sys) disable iff (!rstn)
        (!rd_upper && !clr_all) |=> $stable(lower_q[1]);
    endproperty
    a_lower_hold: assert property (p_lower_hold) else $error("lower word moved");

    property p_two_ch;
        @(posedge clk_sys) disable iff (!rstn)
        (conv_done && !clr_all && (conv_ch > 2'h1))
            |=> (unread_q[$past(conv_ch)] == FOUR_CHANNEL);
    endproperty
    a_two_ch: assert property (p_two_ch) else $error("absent channel flagged");
endmodule : status_readback

`default_nettype wire

//--- rtl/status_readback_pkg.sv
// register map, field layout and reset values of the status and readback block
package status_readback_pkg;
    // register offsets, as the host addresses them
    localparam logic [7:0] OFS_RESULT_UPPER0 = 8'h00;
    localparam logic [7:0] OFS_RESULT_LOWER0 = 8'h01;
    localparam logic [7:0] OFS_EVENT_STATUS = 8'h18;
    localparam logic [7:0] OFS_FAULT_REPORT_MASK = 8'h19;
    localparam logic [7:0] OFS_DEVICE_CONFIG = 8'h1A;
    localparam logic [7:0] OFS_CHANNEL_SEQUENCE_CONFIG = 8'h1B;
    localparam logic [7:0] OFS_SOFT_RESET = 8'h1C;
    // event_status field positions
    localparam int ST_UNREAD_LSB = 0;
    localparam int ST_DRDY_BIT = 6;
    localparam int ST_ERR_LSB = 8;
    localparam int ST_FCH_LSB = 14;
    localparam int NUM_ERR = 6;
    localparam int NUM_CH = 4;
    // fault_report_mask: error enables share the status positions
    localparam int MASK_DRDY_BIT = 0;
    // device config and soft reset fields
    localparam int CFG_SLEEP_BIT = 13;
    localparam int CFG_IRQ_DIS_BIT = 7;
    localparam int SOFT_RESET_BIT = 15;
    // channel sequence config fields
    localparam int SEQ_DEGLITCH_LSB = 0;
    // reset values
    localparam logic [15:0] RST_FAULT_REPORT_MASK = 16'h0000;
    localparam logic [15:0] RST_DEVICE_CONFIG = 16'h2000;
    localparam logic [15:0] RST_CHANNEL_SEQUENCE_CONFIG = 16'h0007;
    // deglitch field encodings
    localparam logic [2:0] DGL_1P0 = 3'h1;
    localparam logic [2:0] DGL_3P3 = 3'h4;
    localparam logic [2:0] DGL_10 = 3'h5;
    localparam logic [2:0] DGL_33 = 3'h3;
    // decoded filter bandwidth shared by every input
    typedef enum logic [1:0] {
        BW_1P0MHZ = 2'h0,
        BW_3P3MHZ = 2'h1,
        BW_10MHZ = 2'h3,
        BW_33MHZ = 2'h2
    } deglitch_bw_t;
endpackage : status_readback_pkg

//--- verif/link_host.sv
// host-side model of the register port, one request at a time
`timescale 1ns/10ps
`default_nettype none

module link_host (
    input wire logic clk_link,
    input wire logic link_ack,
    input wire logic [15:0] link_rdata,
    output logic link_req,
    output logic link_wr,
    output logic [7:0] link_addr,
    output logic [15:0] link_wdata
);
    // idle values at time zero
    initial begin
        link_req = 1'b0;
        link_wr = 1'b0;
        link_addr = 8'hFF;
        link_wdata = 16'h0000;
    end

    // pulse the request, hold address and data until the answer edge
    task automatic access(input logic wr, input logic [7:0] addr, input logic [15:0] wdata,
                          output logic [15:0] rdata);
        int n;
        n = 0;
        @(posedge clk_link);
        link_req <= 1'b1;
        link_wr <= wr;
        link_addr <= addr;
        link_wdata <= wdata;
        @(posedge clk_link);
        link_req <= 1'b0;
        // bounded wait, a lost answer shows up as unknown data
        while (link_ack !== 1'b1 && n < 12) begin
            @(posedge clk_link);
            n = n + 1;
        end
        rdata = (n < 12) ? link_rdata : 16'hXXXX;
        // released qualifiers no longer show the last value
        link_wr <= ~wr;
        link_addr <= ~addr;
        link_wdata <= ~wdata;
    endtask : access
endmodule : link_host

`default_nettype wire

//--- verif/test_status_readback.sv
// self-checking bench of the status, interrupt and readback block
`timescale 1ns/10ps
`default_nettype none

module test_status_readback
    import status_readback_pkg::*;
;
    logic clk_sys = 1'b0; // system clock
    logic clk_link = 1'b0; // register port clock
    logic rstn = 1'b0; // active low reset
    logic conv_done = 1'b0; // conversion strobe
    logic [1:0] conv_ch = 2'h0;
    logic [27:0] conv_data = 28'h0000000;
    logic conv_last = 1'b0;
    logic [NUM_ERR-1:0] err_event = 6'h00; // error strobes
    logic [1:0] err_ch = 2'h0;
    logic shutdown_pin = 1'b0;
    logic link_req, link_wr, link_ack, link_busy, irq_n_pin, sleep_mode;
    logic [7:0] link_addr;
    logic [15:0] link_wdata, link_rdata;
    deglitch_bw_t deglitch_bw;
    int err_count = 0; // mismatches
    int n_checks = 0; // comparisons
    logic [2:0] codes [5] = '{DGL_1P0, DGL_3P3, DGL_10, DGL_33, 3'h0};
    deglitch_bw_t bws [5] = '{BW_1P0MHZ, BW_3P3MHZ, BW_10MHZ, BW_33MHZ, BW_33MHZ};

    // 200 MHz system clock
    always #2.5 clk_sys = ~clk_sys;
    // 8 MHz link clock, offset so its edges never meet the system clock
    initial begin
        #1.3;
        forever #62.5 clk_link = ~clk_link;
    end

    status_readback #(.FOUR_CHANNEL(1'b1)) status_readback_inst (
        .clk_sys(clk_sys), .rstn(rstn), .conv_done(conv_done), .conv_ch(conv_ch),
        .conv_data(conv_data), .conv_last(conv_last), .err_event(err_event),
        .err_ch(err_ch), .shutdown_pin(shutdown_pin), .clk_link(clk_link),
        .link_req(link_req), .link_wr(link_wr), .link_addr(link_addr),
        .link_wdata(link_wdata), .link_ack(link_ack), .link_busy(link_busy),
        .link_rdata(link_rdata), .irq_n_pin(irq_n_pin), .sleep_mode(sleep_mode),
        .deglitch_bw(deglitch_bw)
    );

    link_host link_host_inst (
        .clk_link(clk_link), .link_ack(link_ack), .link_rdata(link_rdata),
        .link_req(link_req), .link_wr(link_wr), .link_addr(link_addr),
        .link_wdata(link_wdata)
    );

    // verdict and end of run, shared with the watchdog
    task automatic print_verdict();
        $display("checks %0d, mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : print_verdict

    // one comparison, reported at once on mismatch
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks = n_checks + 1;
        if (got !== exp) begin
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
            err_count = err_count + 1;
        end
    endtask : chk

    // busy must show on the link edge after a request is taken
    logic req_seen = 1'b0; // request seen at the previous link edge
    always @(posedge clk_link) begin
        if (req_seen) begin
            chk({15'h0000, link_busy}, 16'h0001);
        end
        req_seen <= link_req;
    end

    // register read with expected value
    task automatic rd(input logic [7:0] addr, input logic [15:0] exp);
        logic [15:0] d;
        link_host_inst.access(1'b0, addr, 16'h0000, d);
        chk(d, exp);
    endtask : rd

    // register write, answer data ignored
    task automatic wr(input logic [7:0] addr, input logic [15:0] val);
        logic [15:0] d;
        link_host_inst.access(1'b1, addr, val, d);
    endtask : wr

    // bounded wait for the interrupt pin level, then compare
    task automatic irq(input logic v);
        int n;
        n = 0;
        while (irq_n_pin !== v && n < 400) begin
            @(posedge clk_sys);
            n = n + 1;
        end
        chk({15'h0000, irq_n_pin}, {15'h0000, v});
    endtask : irq

    // one finished conversion, then a few cycles for the snapshot
    task automatic conv(input logic [1:0] ch, input logic [27:0] d, input logic last);
        @(posedge clk_sys);
        conv_done <= 1'b1;
        conv_ch <= ch;
        conv_data <= d;
        conv_last <= last;
        @(posedge clk_sys);
        conv_done <= 1'b0;
        conv_data <= ~d;
        repeat (4) @(posedge clk_sys);
    endtask : conv

    // one error strobe of the first kind on a channel
    task automatic err(input logic [1:0] ch);
        @(posedge clk_sys);
        err_event <= 6'h01;
        err_ch <= ch;
        @(posedge clk_sys);
        err_event <= 6'h00;
        err_ch <= ~ch;
        repeat (4) @(posedge clk_sys);
    endtask : err

    // watchdog: the whole sequence needs well under this
    initial begin
        #400000;
        err_count = err_count + 1;
        print_verdict();
    end

    // main sequence
    initial begin
        // reset long enough for both clocks to see it
        repeat (16) @(posedge clk_sys);
        repeat (2) @(posedge clk_link);
        @(posedge clk_sys);
        rstn <= 1'b1;
        chk({15'h0000, sleep_mode}, 16'h0001);
        rd(OFS_FAULT_REPORT_MASK, RST_FAULT_REPORT_MASK);
        // busy already dropped when the answer is taken
        chk({15'h0000, link_busy}, 16'h0000);
        wr(8'h30, 16'hFFFF);
        rd(8'h30, 16'h0000);
        // every defined filter code plus undefined code 0, one setting for all inputs
        for (int i = 0; i < 5; i++) begin
            wr(OFS_CHANNEL_SEQUENCE_CONFIG, {13'h0000, codes[i]});
            repeat (8) @(posedge clk_sys);
            chk({14'h0000, deglitch_bw}, {14'h0000, bws[i]});
        end
        // wake with ready interrupt enabled, lowest fitting filter band
        wr(OFS_CHANNEL_SEQUENCE_CONFIG, {13'h0000, DGL_3P3});
        wr(OFS_FAULT_REPORT_MASK, 16'h0001);
        rd(OFS_FAULT_REPORT_MASK, 16'h0001);
        wr(OFS_DEVICE_CONFIG, 16'h0000);
        chk({15'h0000, sleep_mode}, 16'h0000);
        conv(2'h0, 28'hABC1234, 1'b1);
        // first status read only after the pin falls
        irq(1'b0);
        rd(OFS_EVENT_STATUS, 16'h0041);
        irq(1'b1);
        rd(8'h00, 16'h0ABC);
        rd(8'h01, 16'h1234);
        // overwrite before reading, only the newest result is kept
        conv(2'h1, 28'h1111111, 1'b0);
        conv(2'h1, 28'h5678ABC, 1'b0);
        rd(OFS_EVENT_STATUS, 16'h0002);
        rd(8'h02, 16'h0567);
        rd(8'h03, 16'h8ABC);
        // lower word alone keeps the old capture
        conv(2'h0, 28'h9876543, 1'b0);
        rd(8'h01, 16'h1234);
        rd(8'h00, 16'h0987);
        rd(8'h01, 16'h6543);
        rd(OFS_EVENT_STATUS, 16'h0000);
        // masked error leaves the pin alone, read clears it
        err(2'h2);
        repeat (20) @(posedge clk_sys);
        chk({15'h0000, irq_n_pin}, 16'h0001);
        rd(OFS_EVENT_STATUS, 16'h8100);
        rd(OFS_EVENT_STATUS, 16'h0000);
        // enabled error drives the pin, output disable overrides it
        wr(OFS_FAULT_REPORT_MASK, 16'h0100);
        err(2'h3);
        irq(1'b0);
        wr(OFS_DEVICE_CONFIG, 16'h0080);
        irq(1'b1);
        wr(OFS_DEVICE_CONFIG, 16'h0000);
        irq(1'b0);
        // sleep drops the interrupt and the results
        wr(OFS_DEVICE_CONFIG, 16'h2000);
        irq(1'b1);
        rd(8'h00, 16'h0000);
        rd(8'h01, 16'h0000);
        wr(OFS_DEVICE_CONFIG, 16'h0000);
        wr(OFS_FAULT_REPORT_MASK, 16'h0101);
        // shutdown pin drops the interrupt and the results
        conv(2'h3, 28'h2468ACE, 1'b1);
        irq(1'b0);
        shutdown_pin <= 1'b1;
        irq(1'b1);
        rd(8'h06, 16'h0000);
        shutdown_pin <= 1'b0;
        // software reset returns mask and sleep to reset values
        wr(OFS_SOFT_RESET, 16'h8000);
        rd(OFS_FAULT_REPORT_MASK, RST_FAULT_REPORT_MASK);
        chk({15'h0000, sleep_mode}, 16'h0001);
        irq(1'b1);
        print_verdict();
    end
endmodule : test_status_readback

`default_nettype wire
